/* File: cac_charge_accounting_core.sv */
// charge accounting core: available charge, discharge tally, learned capacity
// assumes: synchronous inputs, single-cycle count events, APB master on mclk
// Summary of operation
// - empty below 0.90V, fault above 2.00V while shunt charge valid
// - empty detection off at rate threshold, 1s resume
// - battery present above 0.1V, reset rising past 0.25V
// - host reset command resets like insertion
// - temperature code upper hex digit, 10C ranges
// - temperature step steers compensation output and the below 0C check at empty
// - charge increments, discharge/self decrement and tally
// - counts arrive compensated; self temperature-only
// - learned capacity loads programmed count at init
// - full count from capacity and mode pins
// - full reference: programmed absolute, learned relative
// - available charge saturates at learned and zero
// - clear available at init and valid charge after empty
// - fifth segment low at reset loads learned
// - self events tally only while charge nonzero
// - tally clears at full, saturates at FFFFh
// - tally to learned on charge after valid empty
// - over 4096 self counts disqualifies update
// - below 0C at empty disqualifies update
// - readable valid discharge flag
// - charge display below -1mV when enabled
// - corruption after supply recovery clears and reloads
// - capacity pin sampled only just after reset
// - dead band suppresses charge and discharge counts
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cac_charge_accounting_core
  import cac_pkg::*;
#(
  parameter int EDV_RESUME_CYCLES = CAC_EDV_RESUME_MS * CAC_CLK_MHZ * 1000
)(
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   clkEn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire cac_pkg::cac_events_type events,
  input  wire cac_pkg::cac_levels_type levels,
  input  wire logic [3:0]             temperatureStep,
  input  wire cac_pkg::cac_pin_type   capacityPin,
  input  wire logic                   modeAbsolute,
  input  wire logic                   fifthSegmentLowN,
  output logic [3:0]                  compensationStep,
  output logic                        displayActive,
  output logic                        cellOvervoltageFault,
  output logic                        batteryPresent
);
  import cac_pkg::*;

  localparam int RW = $clog2(EDV_RESUME_CYCLES + 1);

  function automatic logic [15:0] pickFullCount(input cac_pin_type pin, input logic absMode);
    logic [15:0] val;
    val = CAC_PFC_REL_Z;
    unique case (pin)
      CAC_PIN_HIGH:  val = absMode ? CAC_PFC_ABS_H : CAC_PFC_REL_H;
      CAC_PIN_FLOAT: val = absMode ? CAC_PFC_ABS_Z : CAC_PFC_REL_Z;
      CAC_PIN_LOW:   val = absMode ? CAC_PFC_ABS_L : CAC_PFC_REL_L;
      default:       val = absMode ? CAC_PFC_ABS_Z : CAC_PFC_REL_Z;
    endcase
    return val;
  endfunction

  logic [15:0]   availCount_reg;
  logic [15:0]   dischargeTally_reg;
  logic [15:0]   learnedCapacity_reg;
  logic [15:0]   programmedFull_reg;
  logic [12:0]   selfCountSinceFull_reg;
  logic [8:0]    chargeRun_reg;
  logic [7:0]    fullShadow_reg;
  logic [RW-1:0] edvResume_reg;
  logic          initPending_reg;
  logic          absMode_reg;
  logic          validDischarge_reg;
  logic          emptyReached_reg;
  logic          validChargeSeen_reg;
  logic          edvEnabled_reg;
  logic          senseLowPrev_reg;
  logic          dispEnable_reg;
  logic          hostReset_reg;
  logic [3:0]    tempCode_reg;

  logic          isFull;
  logic          chargeEv;
  logic          dischargeEv;
  logic          selfEv;
  logic          validChargeNow;
  logic          emptyNow;
  logic          corruptNow;
  logic          insertReset;
  logic          fullReset;
  logic          apbWrite;
  logic          apbAccess;

  assign isFull      = (availCount_reg == learnedCapacity_reg);
  // dead band drops charge and discharge counts; self-discharge still runs
  assign chargeEv    = events.chargeCount & ~levels.shuntDeadBand;
  assign dischargeEv = events.dischargeCount & ~levels.shuntDeadBand;
  assign selfEv      = events.selfCount;
  assign validChargeNow = chargeEv & levels.shuntChargeValid & ~validChargeSeen_reg
                        & (chargeRun_reg == CAC_VALID_CHG);
  assign emptyNow    = edvEnabled_reg & levels.cellBelowEmpty & ~emptyReached_reg;
  assign corruptNow  = levels.supplyRecovered & levels.registerCorrupt;
  assign insertReset = senseLowPrev_reg & ~levels.cellSenseLow;
  assign fullReset   = insertReset | hostReset_reg;
  assign apbAccess   = psel & penable & pready;
  assign apbWrite    = apbAccess & pwrite;

  // battery insertion edge; reset state arms the init sequence
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      senseLowPrev_reg <= 1'b1;
    else if (clkEn)
      senseLowPrev_reg <= levels.cellSenseLow;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      initPending_reg <= 1'b1;
    else if (clkEn)
      initPending_reg <= fullReset;

  // pins are caught while init is pending after reset, insertion or host reset; changes at other times ignored
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      programmedFull_reg <= CAC_PFC_REL_Z;
      absMode_reg        <= 1'b0;
    end
    else if (clkEn && initPending_reg)
    begin
      programmedFull_reg <= pickFullCount(capacityPin, modeAbsolute);
      absMode_reg        <= modeAbsolute;
    end

  // learned capacity
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      learnedCapacity_reg <= CAC_PFC_REL_Z;
    else if (clkEn)
    begin
      if (initPending_reg)
        learnedCapacity_reg <= pickFullCount(capacityPin, modeAbsolute);
      else if (corruptNow)
        learnedCapacity_reg <= programmedFull_reg;
      else if (chargeEv && emptyReached_reg && validDischarge_reg)
        learnedCapacity_reg <= dischargeTally_reg;
    end

  // available charge counter
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      availCount_reg <= CAC_ZERO;
    else if (clkEn)
    begin
      if (initPending_reg)
        availCount_reg <= ~fifthSegmentLowN
                        ? pickFullCount(capacityPin, modeAbsolute)
                        : CAC_ZERO;
      else if (corruptNow)
        availCount_reg <= CAC_ZERO;
      else if (validChargeNow && emptyReached_reg)
        availCount_reg <= CAC_ZERO;
      else if (chargeEv)
      begin
        if (availCount_reg < learnedCapacity_reg)
          availCount_reg <= availCount_reg + 16'h0001;
      end
      else if (dischargeEv || selfEv)
      begin
        if (availCount_reg != CAC_ZERO)
          availCount_reg <= availCount_reg - 16'h0001;
      end
    end

  // discharge tally; a discharge at full still counts rather than being cleared
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      dischargeTally_reg <= CAC_ZERO;
    else if (clkEn)
    begin
      if (initPending_reg || corruptNow)
        dischargeTally_reg <= CAC_ZERO;
      else if ((dischargeEv || (selfEv && availCount_reg != CAC_ZERO))
               && !chargeEv)
      begin
        if (dischargeTally_reg != CAC_TALLY_MAX)
          dischargeTally_reg <= dischargeTally_reg + 16'h0001;
      end
      else if (isFull)
        dischargeTally_reg <= CAC_ZERO;
    end

  // self-discharge counts accumulated since the last full point
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      selfCountSinceFull_reg <= '0;
    else if (clkEn)
    begin
      if (initPending_reg || isFull)
        selfCountSinceFull_reg <= '0;
      else if (selfEv && selfCountSinceFull_reg <= CAC_SELF_LIMIT)
        selfCountSinceFull_reg <= selfCountSinceFull_reg + 13'h0001;
    end

  // sustained charge run; restarts whenever the shunt leaves the charge region
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      chargeRun_reg       <= '0;
      validChargeSeen_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!levels.shuntChargeValid || initPending_reg)
      begin
        chargeRun_reg       <= '0;
        validChargeSeen_reg <= 1'b0;
      end
      else if (chargeEv && !validChargeSeen_reg)
      begin
        if (chargeRun_reg == CAC_VALID_CHG)
          validChargeSeen_reg <= 1'b1;
        else
          chargeRun_reg <= chargeRun_reg + 9'h001;
      end
    end

  // valid discharge flag: armed at full, dropped by any disqualifier
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      validDischarge_reg <= 1'b0;
    else if (clkEn)
    begin
      if (initPending_reg || corruptNow)
        validDischarge_reg <= 1'b0;
      else if (validChargeNow && !emptyReached_reg)
        validDischarge_reg <= 1'b0;
      else if (selfCountSinceFull_reg > CAC_SELF_LIMIT)
        validDischarge_reg <= 1'b0;
      else if (emptyNow && tempCode_reg < CAC_TEMP_ZERO_C)
        validDischarge_reg <= 1'b0;
      else if (chargeEv && emptyReached_reg)
        validDischarge_reg <= 1'b0;
      else if (isFull && !emptyReached_reg)
        validDischarge_reg <= 1'b1;
    end

  // empty state holds until the next valid charge, which must still see it to clear the counter
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      emptyReached_reg <= 1'b0;
    else if (clkEn)
    begin
      if (initPending_reg || corruptNow)
        emptyReached_reg <= 1'b0;
      else if (emptyNow)
        emptyReached_reg <= 1'b1;
      else if (validChargeNow)
        emptyReached_reg <= 1'b0;
    end

  // empty detection is blanked under heavy load: cell sags without being empty
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      edvResume_reg  <= '0;
      edvEnabled_reg <= 1'b1;
    end
    else if (clkEn)
    begin
      if (levels.shuntAboveRate1)
      begin
        edvResume_reg  <= RW'(EDV_RESUME_CYCLES);
        edvEnabled_reg <= 1'b0;
      end
      else if (edvResume_reg > RW'(1))
        edvResume_reg <= edvResume_reg - RW'(1);
      else if (edvResume_reg == RW'(1))
      begin
        edvResume_reg  <= '0;
        edvEnabled_reg <= 1'b1;
      end
    end

  // full arrivals since init, cleared by corruption
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      fullShadow_reg <= '0;
    else if (clkEn)
    begin
      if (initPending_reg || corruptNow)
        fullShadow_reg <= '0;
      else if (chargeEv && availCount_reg + 16'h0001 == learnedCapacity_reg
               && fullShadow_reg != CAC_FULL_MAX)
        fullShadow_reg <= fullShadow_reg + 8'h01;
    end

  // temperature code, clamped to the top range
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      tempCode_reg <= CAC_TEMP_ZERO_C;
    else if (clkEn)
      tempCode_reg <= (temperatureStep > CAC_TEMP_MAX) ? CAC_TEMP_MAX
                                                       : temperatureStep;

  // outputs facing the front end and display driver
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      compensationStep     <= CAC_TEMP_ZERO_C;
      displayActive        <= 1'b0;
      batteryPresent       <= 1'b0;
    end
    else if (clkEn)
    begin
      compensationStep     <= tempCode_reg;
      displayActive        <= dispEnable_reg & levels.shuntBelowDisplay;
      batteryPresent       <= levels.cellPresent;
    end

  // overvoltage fault: sticky, write one to clear, a new fault wins over the clear
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      cellOvervoltageFault <= 1'b0;
    else if (clkEn)
    begin
      if (levels.cellAboveOver && levels.shuntChargeValid)
        cellOvervoltageFault <= 1'b1;
      else if (apbWrite && paddr == CAC_ADDR_STATUS && pwdata[CAC_ST_OVFAULT])
        cellOvervoltageFault <= 1'b0;
    end

  // control register; the reset bit self-clears after one cycle
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      dispEnable_reg <= CAC_CTRL_RESET_VAL[CAC_CTRL_DISPEN];
      hostReset_reg  <= CAC_CTRL_RESET_VAL[CAC_CTRL_RESET];
    end
    else if (clkEn)
    begin
      hostReset_reg <= apbWrite && paddr == CAC_ADDR_CTRL && pwdata[CAC_CTRL_RESET];
      if (apbWrite && paddr == CAC_ADDR_CTRL)
        dispEnable_reg <= pwdata[CAC_CTRL_DISPEN];
    end

  // apb slave: one wait state, answer registered
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (clkEn)
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && penable && !pready)
      begin
        unique case (paddr)
          CAC_ADDR_CTRL:    prdata <= {30'h0, dispEnable_reg, 1'b0};
          CAC_ADDR_STATUS:  prdata <= {25'h0, absMode_reg, validChargeSeen_reg,
                                       edvEnabled_reg, batteryPresent,
                                       cellOvervoltageFault, emptyReached_reg,
                                       validDischarge_reg};
          CAC_ADDR_AVAIL:   prdata <= {16'h0, availCount_reg};
          CAC_ADDR_TALLY:   prdata <= {16'h0, dischargeTally_reg};
          CAC_ADDR_LEARNED: prdata <= {16'h0, learnedCapacity_reg};
          CAC_ADDR_PFC:     prdata <= {16'h0, programmedFull_reg};
          CAC_ADDR_TEMP:    prdata <= {24'h0, tempCode_reg, 4'h0};
          CAC_ADDR_SELF:    prdata <= {19'h0, selfCountSinceFull_reg};
          CAC_ADDR_FULLREF: prdata <= {16'h0, absMode_reg ? programmedFull_reg
                                                          : learnedCapacity_reg};
          CAC_ADDR_SHADOW:  prdata <= {24'h0, fullShadow_reg};
          default:          pslverr <= 1'b1;
        endcase
      end
    end

endmodule

/* File: cac_pkg.sv */
// constants, field layouts and signal bundles of the charge accounting core
// assumes: a 125 MHz clock and a front end that delivers events and comparisons
package cac_pkg;

  localparam int CAC_CLK_MHZ = 125;

  // counter widths and limits
  localparam int             CAC_CW          = 16;
  localparam logic [15:0]    CAC_TALLY_MAX   = 16'hFFFF;
  localparam logic [15:0]    CAC_ZERO        = 16'h0000;
  localparam logic [8:0]     CAC_VALID_CHG   = 9'h100;
  localparam logic [12:0]    CAC_SELF_LIMIT  = 13'h1000;
  localparam logic [7:0]     CAC_FULL_MAX    = 8'hFF;

  // empty detection resumes this long after the rate threshold clears
  localparam int             CAC_EDV_RESUME_MS = 1000;

  // temperature: step 0 is below -30 C, each step 10 C, step 12 above 80 C
  localparam logic [3:0]     CAC_TEMP_MAX    = 4'hC;
  localparam logic [3:0]     CAC_TEMP_ZERO_C = 4'h4;

  // programmed full counts: relative mode high, float, low
  localparam logic [15:0]    CAC_PFC_REL_H   = 16'd27648;
  localparam logic [15:0]    CAC_PFC_REL_Z   = 16'd34304;
  localparam logic [15:0]    CAC_PFC_REL_L   = 16'd44800;
  // absolute mode high, float, low
  localparam logic [15:0]    CAC_PFC_ABS_H   = 16'd42240;
  localparam logic [15:0]    CAC_PFC_ABS_Z   = 16'd31744;
  localparam logic [15:0]    CAC_PFC_ABS_L   = 16'd23808;

  // register byte addresses
  localparam logic [7:0]     CAC_ADDR_CTRL    = 8'h00;
  localparam logic [7:0]     CAC_ADDR_STATUS  = 8'h04;
  localparam logic [7:0]     CAC_ADDR_AVAIL   = 8'h08;
  localparam logic [7:0]     CAC_ADDR_TALLY   = 8'h0C;
  localparam logic [7:0]     CAC_ADDR_LEARNED = 8'h10;
  localparam logic [7:0]     CAC_ADDR_PFC     = 8'h14;
  localparam logic [7:0]     CAC_ADDR_TEMP    = 8'h18;
  localparam logic [7:0]     CAC_ADDR_SELF    = 8'h1C;
  localparam logic [7:0]     CAC_ADDR_FULLREF = 8'h20;
  localparam logic [7:0]     CAC_ADDR_SHADOW  = 8'h24;

  // control bits
  localparam int CAC_CTRL_RESET   = 0;
  localparam int CAC_CTRL_DISPEN  = 1;
  localparam logic [31:0] CAC_CTRL_RESET_VAL = 32'h0000_0002;
  // status bits; the overvoltage fault bit is write-one-to-clear
  localparam int CAC_ST_VALIDDQ   = 0;
  localparam int CAC_ST_EMPTY     = 1;
  localparam int CAC_ST_OVFAULT   = 2;
  localparam int CAC_ST_PRESENT   = 3;
  localparam int CAC_ST_EDVON     = 4;
  localparam int CAC_ST_VALIDCHG  = 5;
  localparam int CAC_ST_ABSMODE   = 6;

  typedef enum logic [1:0] {CAC_PIN_HIGH, CAC_PIN_FLOAT, CAC_PIN_LOW} cac_pin_type;

  // single-cycle compensated count events
  typedef struct packed {
    logic chargeCount;
    logic dischargeCount;
    logic selfCount;
  } cac_events_type;

  // threshold comparisons, already synchronous to mclk
  typedef struct packed {
    logic cellBelowEmpty;     // cell below 0.90 V
    logic cellAboveOver;      // cell above 2.00 V
    logic cellPresent;        // sense above 0.1 V
    logic cellSenseLow;       // sense below 0.25 V
    logic shuntAboveRate1;    // shunt at or above first rate threshold
    logic shuntChargeValid;   // effective shunt below charge threshold
    logic shuntBelowDisplay;  // effective shunt below -1 mV
    logic shuntDeadBand;      // effective shunt inside the dead band
    logic supplyRecovered;    // pulse: supply back above backup threshold
    logic registerCorrupt;    // backup check found lost data
  } cac_levels_type;

endpackage

/* File: cac_charge_accounting_core_properties.sv */
// port-level checks of the charge accounting core
// assumes: bound to the core, one clock domain, async active-low reset
`timescale 1ns/1ps
module cac_charge_accounting_core_properties
  import cac_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    nrst,
  input wire logic                    clkEn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire cac_pkg::cac_levels_type levels,
  input wire logic [3:0]              temperatureStep,
  input wire logic [3:0]              compensationStep,
  input wire logic                    displayActive,
  input wire logic                    cellOvervoltageFault,
  input wire logic                    batteryPresent
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_present;
    $past(nrst) && $past(clkEn) |-> batteryPresent == $past(levels.cellPresent);
  endproperty
  a_present: assert property (p_present) else $error("present flag wrong");
  property p_ovf;
    $past(nrst) && $past(clkEn && levels.cellAboveOver && levels.shuntChargeValid)
      |-> cellOvervoltageFault;
  endproperty
  a_ovf: assert property (p_ovf) else $error("fault not set");
  // two-stage path, both stages must have run out of reset
  property p_comp;
    $past(nrst, 2) && $past(nrst) && $past(clkEn, 2) && $past(clkEn) |->
      compensationStep == (($past(temperatureStep, 2) > 4'hC) ? 4'hC
                                                             : $past(temperatureStep, 2));
  endproperty
  a_comp: assert property (p_comp) else $error("step not forwarded");
  property p_disp;
    $past(nrst) && $past(clkEn) && !$past(levels.shuntBelowDisplay) |-> !displayActive;
  endproperty
  a_disp: assert property (p_disp) else $error("display on without charge");
  property p_wait;
    clkEn && psel && penable && !pready |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_once;
    pready |=> !pready;
  endproperty
  a_once: assert property (p_once) else $error("ready held");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rdz;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer");
endmodule

bind cac_charge_accounting_core cac_charge_accounting_core_properties u_chk (
  .mclk(mclk), .nrst(nrst), .clkEn(clkEn), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .levels(levels),
  .temperatureStep(temperatureStep), .compensationStep(compensationStep),
  .displayActive(displayActive), .cellOvervoltageFault(cellOvervoltageFault),
  .batteryPresent(batteryPresent));

/* File: cac_front_end_model.sv */
// measurement front end: turns requests into one-cycle events, retimes levels
// assumes: requests and levels come from the bench on mclk
`timescale 1ns/1ps
module cac_front_end_model
  import cac_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire cac_pkg::cac_events_type req,
  input  wire cac_pkg::cac_levels_type lvlIn,
  output cac_pkg::cac_events_type      events,
  output cac_pkg::cac_levels_type      levels
);
  cac_events_type reqPrev;
  // edge detect so a held request never gives more than one count
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      reqPrev <= '0;
      events  <= '0;
      levels  <= '0;
    end
    else
    begin
      reqPrev <= req;
      events  <= req & ~reqPrev;
      levels  <= lvlIn;
    end
endmodule

/* File: cac_charge_accounting_core_tb.sv */
// self-checking bench of the charge accounting core
// assumes: front end model in front, APB master here, short resume count
`timescale 1ns/1ps
module cac_charge_accounting_core_tb;
  import cac_pkg::*;
  localparam logic [31:0] M = 32'h0000_FFFF;
  logic           mclk, nrst, clkEn, psel, penable, pwrite, pready, pslverr;
  logic           modeAbsolute, fifthSegmentLowN, displayActive, lastErr;
  logic           cellOvervoltageFault, batteryPresent;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, q, P;
  logic [3:0]     temperatureStep, compensationStep;
  cac_pin_type    capacityPin, p;
  cac_events_type req, events;
  cac_levels_type lv, levels;
  int             error_cnt, cmp_count, k;

  cac_front_end_model fe (.mclk(mclk), .nrst(nrst), .req(req), .lvlIn(lv),
    .events(events), .levels(levels));
  cac_charge_accounting_core #(.EDV_RESUME_CYCLES(20)) dut (.mclk(mclk), .nrst(nrst),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .events(events), .levels(levels), .temperatureStep(temperatureStep),
    .capacityPin(capacityPin), .modeAbsolute(modeAbsolute),
    .fifthSegmentLowN(fifthSegmentLowN), .compensationStep(compensationStep),
    .displayActive(displayActive), .cellOvervoltageFault(cellOvervoltageFault),
    .batteryPresent(batteryPresent));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic results;
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // idle edge first so a release and a new setup never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      results;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic ev(input cac_events_type e, input int n);
    repeat (n)
    begin
      @(posedge mclk) req <= e;
      @(posedge mclk) req <= '0;
    end
    repeat (3) @(posedge mclk);
  endtask

  task automatic rst(input cac_pin_type c, input logic m, input logic f);
    nrst <= 1'b0;
    capacityPin <= c;
    modeAbsolute <= m;
    fifthSegmentLowN <= f;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // rate threshold first, so empty is seen only after the resume delay
  task automatic drain(input logic [3:0] t);
    temperatureStep <= t;
    lv.shuntAboveRate1 <= 1'b1;
    repeat (3) @(posedge mclk);
    lv.cellBelowEmpty <= 1'b1;
    repeat (5) @(posedge mclk);
    rd(CAC_ADDR_STATUS, 32'h2, 32'h0);
    lv.shuntAboveRate1 <= 1'b0;
    rd(CAC_ADDR_STATUS, 32'h2, 32'h0);
    repeat (30) @(posedge mclk);
    rd(CAC_ADDR_STATUS, 32'h2, 32'h2);
    ev(3'b100, 1);
    lv.cellBelowEmpty <= 1'b0;
  endtask

  function automatic logic [31:0] programmed_full_capacity(input cac_pin_type c, input logic m);
    case (c)
      CAC_PIN_HIGH:  programmed_full_capacity = m ? 32'h0000_A500 : 32'h0000_6C00;
      CAC_PIN_FLOAT: programmed_full_capacity = m ? 32'h0000_7C00 : 32'h0000_8600;
      default:       programmed_full_capacity = m ? 32'h0000_5D00 : 32'h0000_AF00;
    endcase
  endfunction

  initial
  begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    results;
  end

  initial
  begin
    void'($urandom(32'h9036));
    {error_cnt, cmp_count} = '0;
    {nrst, psel, penable, pwrite, paddr, pwdata, req, lv} = '0;
    lv.cellPresent = 1'b1;
    clkEn = 1'b1;
    temperatureStep = 4'h6;
    {modeAbsolute, fifthSegmentLowN} = 2'b01;
    capacityPin = CAC_PIN_HIGH;
    for (int i = 0; i < 6; i++)
    begin
      p = cac_pin_type'(i % 3);
      rst(p, i > 2, i[0]);
      rd(CAC_ADDR_PFC, M, programmed_full_capacity(p, i > 2));
      rd(CAC_ADDR_LEARNED, M, programmed_full_capacity(p, i > 2));
      rd(CAC_ADDR_AVAIL, M, i[0] ? 32'h0 : programmed_full_capacity(p, i > 2));
      capacityPin <= cac_pin_type'((i + 1) % 3);
      rd(CAC_ADDR_PFC, M, programmed_full_capacity(p, i > 2));
    end
    rst(CAC_PIN_LOW, 1'b1, 1'b0);
    P = 32'h0000_5D00;
    rd(CAC_ADDR_STATUS, 32'h1, 32'h1);
    ev(3'b100, 1);
    rd(CAC_ADDR_AVAIL, M, P);
    lv.shuntDeadBand <= 1'b1;
    ev(3'b010, 2);
    lv.shuntDeadBand <= 1'b0;
    rd(CAC_ADDR_AVAIL, M, P);
    k = 1 + $urandom % 30;
    ev(3'b010, k);
    ev(3'b001, 5);
    rd(CAC_ADDR_AVAIL, M, P - k - 5);
    rd(CAC_ADDR_TALLY, M, k + 5);
    drain(4'h5);
    rd(CAC_ADDR_LEARNED, M, k + 5);
    rd(CAC_ADDR_FULLREF, M, P);
    rd(CAC_ADDR_STATUS, 32'h1, 32'h0);
    lv.shuntChargeValid <= 1'b1;
    ev(3'b100, 259);
    rd(CAC_ADDR_AVAIL, M, 32'h2);
    @(posedge mclk) lv.supplyRecovered <= 1'b1;
    lv.registerCorrupt <= 1'b1;
    @(posedge mclk) lv.supplyRecovered <= 1'b0;
    rd(CAC_ADDR_AVAIL, M, 32'h0);
    rd(CAC_ADDR_LEARNED, M, P);
    lv.registerCorrupt <= 1'b0;
    apb(1'b1, CAC_ADDR_CTRL, 32'h3);
    rd(CAC_ADDR_AVAIL, M, P);
    ev(3'b010, 4);
    ev(3'b100, 4);
    rd(CAC_ADDR_TALLY, M, 32'h0);
    drain(4'h3);
    rd(CAC_ADDR_LEARNED, M, P);
    rst(CAC_PIN_HIGH, 1'b0, 1'b1);
    ev(3'b010, 3);
    ev(3'b001, 2);
    rd(CAC_ADDR_AVAIL, M, 32'h0);
    rd(CAC_ADDR_TALLY, M, 32'h3);
    for (int t = 0; t < 16; t++)
    begin
      temperatureStep <= t[3:0];
      rd(CAC_ADDR_TEMP, 32'hFF, (t > 12 ? 12 : t) << 4);
    end
    lv.cellAboveOver <= 1'b1;
    lv.shuntChargeValid <= 1'b1;
    lv.shuntBelowDisplay <= 1'b1;
    lv.cellPresent <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(displayActive, 32'h1);
    chk(cellOvervoltageFault, 32'h1);
    chk(batteryPresent, 32'h0);
    lv.cellAboveOver <= 1'b0;
    apb(1'b1, CAC_ADDR_STATUS, 32'h4);
    rd(CAC_ADDR_STATUS, 32'h4, 32'h0);
    // discharges while the enable is low must leave the tally alone
    clkEn <= 1'b0;
    ev(3'b010, 2);
    clkEn <= 1'b1;
    rd(CAC_ADDR_TALLY, M, 32'h3);
    rd(8'h40, 32'hFFFF_FFFF, 32'h0);
    chk(lastErr, 32'h1);
    results;
  end
endmodule
